// file: src/iaoe_consts.svh
// Constants for the increment and OR execute block
`ifndef IAOE_CONSTS_SVH
`define IAOE_CONSTS_SVH
`define IAOE_DATA_W      8
`define IAOE_ADDR_W      7
`define IAOE_ZERO_BYTE   8'h00
`define IAOE_ONE_BYTE    8'h01
`define IAOE_ALL_ONES    8'hff
`define IAOE_ADDR_ZERO   7'h00
`define IAOE_W_RESET     8'h00
`define IAOE_DEST_W      1'b0
`define IAOE_DEST_F      1'b1
`endif

// file: src/iaoe_pkg.sv
// Types for the increment and OR execute block
package iaoe_pkg;
  // Operation select presented by the fetch/decode stage
  typedef enum logic [2:0] {
    IAOE_OP_NONE,
    IAOE_OP_INCREMENT_SKIP_IF_ZERO,
    IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR,
    IAOE_OP_INCREMENT_FILE_REGISTER,
    IAOE_OP_OR_ACCUMULATOR_WITH_FILE
  } iaoe_op_t;
  // Execute sequencer state
  typedef enum logic [0:0] {
    IAOE_ST_RUN,
    IAOE_ST_SKIP
  } iaoe_state_t;
endpackage : iaoe_pkg

// file: src/iaoe_alu.sv
// Combinational ALU for increment and inclusive OR
`timescale 1ns/1ps
`include "iaoe_consts.svh"
module iaoe_alu (
  input  wire iaoe_pkg::iaoe_op_t op_i,     // Operation
  input  wire logic [7:0]         acc_i,    // Working register
  input  wire logic [7:0]         file_i,   // File register operand
  input  wire logic [7:0]         lit_i,    // Literal operand
  output logic      [7:0]         res_o,    // Result
  output logic                    zero_o    // Result equals zero
);
  // Result select
  always_comb begin
    case (op_i)
      iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO,
      iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER: begin
        res_o = file_i + `IAOE_ONE_BYTE; // RL1 RL6
      end
      iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR: begin
        res_o = acc_i | lit_i;        // RL4 RL5
      end
      iaoe_pkg::IAOE_OP_OR_ACCUMULATOR_WITH_FILE: begin
        res_o = acc_i | file_i;       // RL7
      end
      default: begin
        res_o = `IAOE_ZERO_BYTE;
      end
    endcase
  end
  // Zero detect on the full 8-bit result
  assign zero_o = (res_o == `IAOE_ZERO_BYTE); // RL8
endmodule : iaoe_alu

// file: src/iaoe_core.sv
// Execute stage for increment, increment-skip and inclusive OR operations
// Function
// RL1: Increment-skip adds one, leaves flags unchanged
// RL2: Destination 0 to accumulator, 1 to file
// RL3: Zero increment-skip result turns next into no-op
// RL4: Literal OR into accumulator, updates zero flag
// RL5: Any literal 0..255 accepted, only zero flag
// RL6: Plain increment updates zero flag, never skips
// RL7: Register OR routes per destination, updates zero
// RL8: Zero flag set iff result is zero
`timescale 1ns/1ps
`include "iaoe_consts.svh"
module iaoe_core (
  input  wire logic               clk_i,      // 50 MHz core clock
  input  wire logic               nrst_i,     // Async reset, active low
  input  wire logic               valid_i,    // Instruction presented this cycle
  input  wire iaoe_pkg::iaoe_op_t op_i,       // Decoded operation
  input  wire logic [6:0]         faddr_i,    // File register address
  input  wire logic               dest_i,     // Destination bit
  input  wire logic [7:0]         lit_i,      // 8-bit literal
  input  wire logic [7:0]         frd_i,      // File register read data
  output logic      [6:0]         fraddr_o,   // File register read address
  output logic                    fwe_o,      // File write enable (pulse)
  output logic      [6:0]         fwaddr_o,   // File write address
  output logic      [7:0]         fwdata_o,   // File write data
  output logic      [7:0]         acc_o,      // Working register
  output logic                    zflag_o,    // Zero status flag
  output logic                    skip_o,     // Current slot executes as no-op
  output logic                    ready_o     // Stage accepts an instruction
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  // Every result is registered so the outputs never glitch towards the file or flags
  iaoe_pkg::iaoe_state_t st_q, st_d;          // Sequencer state
  logic [7:0]            acc_q, acc_d;        // Working register
  logic                  z_q, z_d;            // Zero flag
  logic                  fwe_q, fwe_d;        // File write strobe
  logic [6:0]            fwa_q, fwa_d;        // File write address
  logic [7:0]            fwd_q, fwd_d;        // File write data
  logic [7:0]            res;                 // ALU result
  logic                  res_zero;            // ALU zero detect
  logic                  exec;                // Instruction really executes

  // Does this operation carry a destination bit
  // Literal OR always writes the accumulator, whatever dest_i says
  function automatic logic has_dest(input iaoe_pkg::iaoe_op_t op);
    has_dest = (op == iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO) ||
               (op == iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER) ||
               (op == iaoe_pkg::IAOE_OP_OR_ACCUMULATOR_WITH_FILE);
  endfunction : has_dest

  // Does this operation update the zero flag
  // Increment-skip is left out on purpose: it touches no status flag
  function automatic logic sets_zero(input iaoe_pkg::iaoe_op_t op);
    sets_zero = (op == iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR) ||
                (op == iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER) ||
                (op == iaoe_pkg::IAOE_OP_OR_ACCUMULATOR_WITH_FILE);
  endfunction : sets_zero

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  // The ALU is shared by all four operations; only the routing below differs
  iaoe_alu u_alu (
    .op_i   (op_i),
    .acc_i  (acc_q),
    .file_i (frd_i),
    .lit_i  (lit_i),
    .res_o  (res),
    .zero_o (res_zero)
  );

  // File is read combinationally at the presented address
  // Limitation: the file must answer within the same cycle, there is no stall
  assign fraddr_o = faddr_i;
  // The slot after a zero increment-skip is swallowed
  assign exec     = valid_i && (st_q == iaoe_pkg::IAOE_ST_RUN); // RL3
  // Always ready: the skipped slot consumes the following instruction
  // Back-pressure is never needed, so ready is a constant rather than a register
  assign ready_o  = 1'b1;
  assign skip_o   = (st_q == iaoe_pkg::IAOE_ST_SKIP);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state and result routing
  // Defaults hold the data registers, so only the taken branch says what changes;
  // the sequencer defaults to run and the file strobe to low, which makes the strobe a one-cycle pulse
  always_comb begin
    st_d  = iaoe_pkg::IAOE_ST_RUN;
    acc_d = acc_q;
    z_d   = z_q;
    fwe_d = 1'b0;
    fwa_d = fwa_q;
    fwd_d = fwd_q;
    if (st_q == iaoe_pkg::IAOE_ST_SKIP) begin
      // No-op slot: nothing written, wait for the next instruction to pass
      st_d = valid_i ? iaoe_pkg::IAOE_ST_RUN : iaoe_pkg::IAOE_ST_SKIP; // RL3
    end else if (exec && op_i != iaoe_pkg::IAOE_OP_NONE) begin
      // Route the result
      if (has_dest(op_i) && dest_i == `IAOE_DEST_F) begin
        fwe_d = 1'b1;                          // RL2
        fwa_d = faddr_i;
        fwd_d = res;
      end else begin
        acc_d = res;                           // RL2 RL4
      end
      // Flag update; increment-skip leaves flags alone
      if (sets_zero(op_i)) begin
        z_d = res_zero;                        // RL8 RL5 RL6 RL7
      end
      // Increment-skip wrapping to zero arms the no-op slot
      // The skip decision uses the ALU result, so it holds for either destination
      if (op_i == iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO && res_zero) begin
        st_d = iaoe_pkg::IAOE_ST_SKIP;         // RL3
      end
    end
  end

  // Register stage only
  // Reset puts the sequencer in the run state, so no slot is swallowed after reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q  <= iaoe_pkg::IAOE_ST_RUN;
      acc_q <= `IAOE_W_RESET;
      z_q   <= 1'b0;
      fwe_q <= 1'b0;
      fwa_q <= `IAOE_ADDR_ZERO;
      fwd_q <= `IAOE_ZERO_BYTE;
    end else begin
      st_q  <= st_d;
      acc_q <= acc_d;
      z_q   <= z_d;
      fwe_q <= fwe_d;
      fwa_q <= fwa_d;
      fwd_q <= fwd_d;
    end
  end

  assign acc_o    = acc_q;
  assign zflag_o  = z_q;
  assign fwe_o    = fwe_q;
  assign fwaddr_o = fwa_q;
  assign fwdata_o = fwd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Checks watch registered state one edge after an instruction is taken,
  // so what they judge is what the core drives, not what the source presents;
  // the no-op slot is checked from the sequencer state, whatever the spacing.

  // Increment-skip must leave the zero flag exactly as it was
  skip_flags_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL1
    exec && op_i == iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO |=> $stable(z_q))
    else $error("increment-skip changed zero flag");

  // Incremented value lands at whichever destination was picked
  inc_result_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL1
    exec && (op_i == iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO ||
             op_i == iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER)
    |=> (fwe_q ? fwd_q : acc_q) == $past(frd_i) + `IAOE_ONE_BYTE)
    else $error("increment result wrong");

  // Destination bit set: file strobe with the result, accumulator kept
  dest_file_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL2
    exec && has_dest(op_i) && dest_i == `IAOE_DEST_F
    |=> fwe_q && fwd_q == $past(res) && $stable(acc_q))
    else $error("destination file not honoured");

  // Destination bit clear, or no destination: accumulator takes the result
  dest_acc_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL2
    exec && op_i != iaoe_pkg::IAOE_OP_NONE && !(has_dest(op_i) && dest_i == `IAOE_DEST_F)
    |=> !fwe_q && acc_q == $past(res))
    else $error("destination accumulator not honoured");

  // Zero increment-skip result arms the no-op slot
  skip_arm_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL3
    exec && op_i == iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO && frd_i == `IAOE_ALL_ONES
    |=> skip_o)
    else $error("following instruction not skipped");

  // The swallowed instruction changes nothing and closes the no-op slot
  skip_slot_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL3
    st_q == iaoe_pkg::IAOE_ST_SKIP && valid_i
    |=> !fwe_q && $stable(acc_q) && $stable(z_q) && !skip_o)
    else $error("swallowed instruction had an effect");

  // With nothing presented the no-op slot stays armed
  skip_wait_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL3
    st_q == iaoe_pkg::IAOE_ST_SKIP && !valid_i
    |=> skip_o && !fwe_q)
    else $error("no-op slot lost before an instruction");

  // A nonzero increment-skip result lets the next instruction run
  no_skip_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL3
    exec && op_i == iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO && frd_i != `IAOE_ALL_ONES
    |=> st_q == iaoe_pkg::IAOE_ST_RUN)
    else $error("skip taken on nonzero result");

  // Literal OR result, worked out from the previous accumulator
  or_lit_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL4
    exec && op_i == iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR
    |=> acc_q == ($past(acc_q) | $past(lit_i)))
    else $error("literal OR result wrong");

  // Literal OR never writes the file and its flag tracks the new accumulator
  lit_flags_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL5
    exec && op_i == iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR
    |=> !fwe_q && z_q == (acc_q == `IAOE_ZERO_BYTE))
    else $error("literal OR side effect wrong");

  // Plain increment flags a wrap and never arms a skip
  inc_plain_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL6
    exec && op_i == iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER
    |=> st_q == iaoe_pkg::IAOE_ST_RUN && z_q == ($past(frd_i) == `IAOE_ALL_ONES))
    else $error("plain increment wrong");

  // Register OR flag, worked out from both operands
  or_file_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL7
    exec && op_i == iaoe_pkg::IAOE_OP_OR_ACCUMULATOR_WITH_FILE
    |=> z_q == (($past(acc_q) | $past(frd_i)) == `IAOE_ZERO_BYTE))
    else $error("register OR zero flag wrong");

  // Any flag-setting instruction leaves the flag equal to a zero result
  zero_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RL8
    exec && sets_zero(op_i) |=> z_q == ($past(res) == `IAOE_ZERO_BYTE))
    else $error("zero flag does not match result");
endmodule : iaoe_core

// file: bench/tb_top.sv
// Self-checking bench for the increment and OR execute stage
`timescale 1ns/1ps
module tb_top;
  logic               clk_i;          // Core clock
  logic               nrst_i;         // Async reset, active low
  logic               valid_i;        // Instruction strobe
  iaoe_pkg::iaoe_op_t op_i;           // Operation
  logic [6:0]         faddr_i;        // File address
  logic               dest_i;         // Destination bit
  logic [7:0]         lit_i;          // Literal
  logic [7:0]         frd_i;          // File read data
  logic [6:0]         fraddr_o;       // File read address
  logic               fwe_o;          // File write pulse
  logic [6:0]         fwaddr_o;       // File write address
  logic [7:0]         fwdata_o;       // File write data
  logic [7:0]         acc_o;          // Working register
  logic               zflag_o;        // Zero flag
  logic               skip_o;         // No-op slot
  logic               ready_o;        // Accepts
  logic [7:0]         mem [0:127];    // File register model
  int                 mismatches;     // Failed compares
  int                 samples_checked; // All compares
  iaoe_core u_iaoe_core (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i), .op_i(op_i),
    .faddr_i(faddr_i), .dest_i(dest_i), .lit_i(lit_i), .frd_i(frd_i), .fraddr_o(fraddr_o),
    .fwe_o(fwe_o), .fwaddr_o(fwaddr_o), .fwdata_o(fwdata_o), .acc_o(acc_o),
    .zflag_o(zflag_o), .skip_o(skip_o), .ready_o(ready_o));
  // Read port is combinational, so the model answers in the same cycle
  assign frd_i = mem[fraddr_o];
  // Write port lands one edge after the pulse is seen
  always @(posedge clk_i) begin
    if (fwe_o) begin
      mem[fwaddr_o] <= fwdata_o;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One instruction, then one idle slot; outputs settled on return
  task automatic iss(input iaoe_pkg::iaoe_op_t o, input logic [6:0] a, input logic d,
                     input logic [7:0] k);
    @(posedge clk_i);
    valid_i <= 1'b1;
    op_i    <= o;
    faddr_i <= a;
    dest_i  <= d;
    lit_i   <= k;
    @(posedge clk_i);
    valid_i <= 1'b0;
    #1;
  endtask : iss
  ////////////////////////////////////////////////////////////////////////////
  // Wrap to zero: file write, flag kept, next instruction swallowed
  task automatic t_skip();
    iss(iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b0, 8'h00);
    chk({7'h00, zflag_o}, 8'h01);
    mem[5] = 8'hff;
    iss(iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO, 7'h05, 1'b1, 8'h00);
    chk({fwe_o, fwaddr_o}, 8'h85);
    chk({1'b0, fraddr_o}, 8'h05);
    chk(fwdata_o, 8'h00);
    chk({7'h00, zflag_o}, 8'h01);
    chk({7'h00, skip_o}, 8'h01);
    iss(iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b0, 8'hff);
    chk(acc_o, 8'h00);
    chk({6'h00, skip_o, fwe_o}, 8'h00);
    // Non-zero result goes to the accumulator and nothing is skipped
    mem[6] = 8'h10;
    iss(iaoe_pkg::IAOE_OP_INCREMENT_SKIP_IF_ZERO, 7'h06, 1'b0, 8'h00);
    chk({acc_o[6:0], skip_o}, 8'h22);
    chk({fwe_o, 6'h00, zflag_o}, 8'h01);
    $display("test skip done");
  endtask : t_skip
  // Literal OR with a top-bit literal and with the all-ones literal
  task automatic t_orl();
    iss(iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b1, 8'h80);
    chk(acc_o, 8'h91);
    chk({fwe_o, 6'h00, zflag_o}, 8'h00);
    iss(iaoe_pkg::IAOE_OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, 1'b0, 8'hff);
    chk(acc_o, 8'hff);
    $display("test orl done");
  endtask : t_orl
  // Plain increment: wraps into the file without skipping, then increments into the accumulator
  task automatic t_inc();
    mem[9] = 8'hff;
    iss(iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER, 7'h09, 1'b1, 8'h00);
    chk({fwe_o, fwaddr_o}, 8'h89);
    chk({fwdata_o[6:0], zflag_o}, 8'h01);
    chk({acc_o[6:0], skip_o}, 8'hfe);
    iss(iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER, 7'h09, 1'b0, 8'h00);
    chk({acc_o[6:0], zflag_o}, 8'h02);
    $display("test inc done");
  endtask : t_inc
  // Register OR to file, then to accumulator with a zero result
  task automatic t_orf();
    mem[3] = 8'h40;
    iss(iaoe_pkg::IAOE_OP_OR_ACCUMULATOR_WITH_FILE, 7'h03, 1'b1, 8'h00);
    chk(fwdata_o, 8'h41);
    chk({fwe_o, fwaddr_o}, 8'h83);
    // Clear the accumulator by wrapping an increment into it
    mem[7] = 8'hff;
    iss(iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER, 7'h07, 1'b0, 8'h00);
    chk({acc_o[6:0], zflag_o}, 8'h01);
    // Nonzero increment to the file clears the flag, accumulator kept
    iss(iaoe_pkg::IAOE_OP_INCREMENT_FILE_REGISTER, 7'h08, 1'b1, 8'h00);
    chk({acc_o[6:0], zflag_o}, 8'h00);
    mem[4] = 8'h00;
    iss(iaoe_pkg::IAOE_OP_OR_ACCUMULATOR_WITH_FILE, 7'h04, 1'b0, 8'h00);
    chk({acc_o[6:0], zflag_o}, 8'h01);
    $display("test orf done");
  endtask : t_orf
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Clock at 50 MHz
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    {nrst_i, valid_i, dest_i, faddr_i, lit_i} = '0;
    op_i = iaoe_pkg::IAOE_OP_NONE;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    chk({acc_o[6:0], zflag_o}, 8'h00);
    chk({ready_o, skip_o, fwe_o, 5'h00}, 8'h80);
    t_skip();
    t_orl();
    t_inc();
    t_orf();
    complete_run();
  end
  // Watchdog: the tests need well under a hundred cycles
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule : tb_top
